// ---- bpab_port_core.sv ----
// Two bidirectional GPIO ports with an Avalon-MM register slave.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`include "bpab_consts.svh"

// How it works
// - Direction bit clear drives the pin from its output latch bit.
// - Direction bit set turns the pin driver off, pin becomes input.
// - Second port has eight pins, each with direction and latch bit.
// - Second port latch is read and written directly, reads return latch value.
// - First port bits 7 and 6 are unimplemented and read zero.
// - Analog-enabled first port pins read zero on the digital path.
// - Output pins drive latch data even while analog input is enabled.
// - After reset, pins 0 to 3 and 5 of the first port are analog inputs.
// - First port bit four resets as a digital input, never analog.
// - First port bit four feeds the timer clock input regardless of direction.
// - Comparator reference output disables driver and input of first port bit two.
// - Second port pins are digital only, without any analog function.
// - First port pins read the pin levels; writes update the latch.
// - A four-bit field in the converter control selects analog or digital pins.
module bpab_port_core
  import bpab_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire bpab_pins_t  pins_in,
  output bpab_pins_t       pins_out,
  output bpab_pins_t       pins_oe,
  output logic             timer_ext_clock_in
);

  // Address decode, shared by the read and the write path.
  function automatic bpab_sel_t decode_sel(input logic [4:0] addr);
    bpab_sel_t sel;
    sel = BPAB_SEL_NONE;
    unique case (addr)
      `BPAB_OFS_A_PINS:   sel = BPAB_SEL_A_PINS;
      `BPAB_OFS_A_LATCH:  sel = BPAB_SEL_A_LATCH;
      `BPAB_OFS_A_DIR:    sel = BPAB_SEL_A_DIR;
      `BPAB_OFS_CONV_CFG: sel = BPAB_SEL_CONV_CFG;
      `BPAB_OFS_B_PINS:   sel = BPAB_SEL_B_PINS;
      `BPAB_OFS_B_LATCH:  sel = BPAB_SEL_B_LATCH;
      `BPAB_OFS_B_DIR:    sel = BPAB_SEL_B_DIR;
      `BPAB_OFS_REF_CTRL: sel = BPAB_SEL_REF_CTRL;
      default:            sel = BPAB_SEL_NONE;
    endcase
    return sel;
  endfunction : decode_sel

  // A converter channel is analog while the config field is below its limit.
  function automatic logic chan_analog(input logic [3:0] cfg, input logic [3:0] ch);
    return cfg < (`BPAB_ANA_LIMIT - ch);
  endfunction : chan_analog

  logic [5:0]  dir_a_q;
  logic [5:0]  latch_a_q;
  logic [7:0]  dir_b_q;
  logic [7:0]  latch_b_q;
  logic [3:0]  cfg_q;
  logic        ref_en_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  bpab_pins_t  sync1_q;
  bpab_pins_t  sync2_q;
  bpab_pins_t  out_q;
  bpab_pins_t  oe_q;
  logic        timer_q;
  logic [5:0]  ana_w;
  logic [5:0]  a_din_w;
  logic [5:0]  a_oe_w;
  logic [7:0]  rd8_w;
  logic        wr_go;
  logic        rd_go;
  logic        wr_lane;
  bpab_sel_t   sel_w;

  assign sel_w   = decode_sel(address);
  assign wr_go   = write && !wait_q;
  assign rd_go   = read && wait_q;
  assign wr_lane = byteenable[0];

  // Pin analog mask; bit four has no converter channel at all.
  assign ana_w[0] = chan_analog(cfg_q, `BPAB_CH_0);
  assign ana_w[1] = chan_analog(cfg_q, `BPAB_CH_1);
  assign ana_w[2] = chan_analog(cfg_q, `BPAB_CH_2);
  assign ana_w[3] = chan_analog(cfg_q, `BPAB_CH_3);
  assign ana_w[4] = 1'b0;
  assign ana_w[5] = chan_analog(cfg_q, `BPAB_CH_4);

  // Per-pin digital input path and driver enable of the first port.
  for (genvar i = 0; i < `BPAB_A_WIDTH; i++)
  begin : g_pin_a
    if (i == `BPAB_REF_PIN)
    begin : g_ref
      // The reference output owns this pin, so both digital paths yield.
      assign a_din_w[i] = sync2_q.a[i] & ~ana_w[i] & ~ref_en_q;
      assign a_oe_w[i]  = ~dir_a_q[i] & ~ref_en_q;
    end
    else
    begin : g_plain
      assign a_din_w[i] = sync2_q.a[i] & ~ana_w[i];
      assign a_oe_w[i]  = ~dir_a_q[i];
    end
  end

  // Bus handshake: one wait cycle, then waitrequest low for exactly one cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
      wait_q <= 1'b1;
    else if (wait_q)
      wait_q <= !(read || write);
    else
      wait_q <= 1'b1;
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    rd8_w = 8'h00;
    unique case (sel_w)
      BPAB_SEL_A_PINS:   rd8_w = {2'b00, a_din_w};
      BPAB_SEL_A_LATCH:  rd8_w = {2'b00, latch_a_q};
      BPAB_SEL_A_DIR:    rd8_w = {2'b00, dir_a_q};
      BPAB_SEL_CONV_CFG: rd8_w = {4'h0, cfg_q};
      BPAB_SEL_B_PINS:   rd8_w = sync2_q.b;
      BPAB_SEL_B_LATCH:  rd8_w = latch_b_q;
      BPAB_SEL_B_DIR:    rd8_w = dir_b_q;
      BPAB_SEL_REF_CTRL: rd8_w = {7'h00, ref_en_q};
      BPAB_SEL_NONE:     rd8_w = 8'h00;
    endcase
  end

  // Read data is captured as the request is first seen and held until the next.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else if (rd_go)
      rdata_q <= {24'h000000, rd8_w};
  end

  // First port latch; pin and latch addresses both write it.
  always_ff @(posedge clk)
  begin
    if (rst)
      latch_a_q <= `BPAB_LAT_A_RST;
    else if (wr_go && wr_lane &&
             (sel_w == BPAB_SEL_A_PINS || sel_w == BPAB_SEL_A_LATCH))
      latch_a_q <= writedata[5:0];
  end

  // First port direction; all pins start as inputs so the analog pins are usable.
  always_ff @(posedge clk)
  begin
    if (rst)
      dir_a_q <= `BPAB_DIR_A_RST;
    else if (wr_go && wr_lane && sel_w == BPAB_SEL_A_DIR)
      dir_a_q <= writedata[5:0];
  end

  // Converter pin config field; zero leaves every channel pin analog.
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= `BPAB_CFG_RST;
    else if (wr_go && wr_lane && sel_w == BPAB_SEL_CONV_CFG)
      cfg_q <= writedata[3:0];
  end

  // Comparator reference output enable.
  always_ff @(posedge clk)
  begin
    if (rst)
      ref_en_q <= `BPAB_REF_RST;
    else if (wr_go && wr_lane && sel_w == BPAB_SEL_REF_CTRL)
      ref_en_q <= writedata[0];
  end

  // Second port latch.
  always_ff @(posedge clk)
  begin
    if (rst)
      latch_b_q <= `BPAB_LAT_B_RST;
    else if (wr_go && wr_lane &&
             (sel_w == BPAB_SEL_B_PINS || sel_w == BPAB_SEL_B_LATCH))
      latch_b_q <= writedata[7:0];
  end

  // Second port direction.
  always_ff @(posedge clk)
  begin
    if (rst)
      dir_b_q <= `BPAB_DIR_B_RST;
    else if (wr_go && wr_lane && sel_w == BPAB_SEL_B_DIR)
      dir_b_q <= writedata[7:0];
  end

  // Two-stage pin synchroniser; only the second stage feeds logic.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // Registered pin drive; costs one cycle of latency but keeps outputs glitch free.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_q <= '0;
      oe_q  <= '0;
    end
    else
    begin
      out_q.a <= latch_a_q;
      out_q.b <= latch_b_q;
      oe_q.a  <= a_oe_w;
      oe_q.b  <= ~dir_b_q;
    end
  end

  // Timer clock input follows the pin whatever its direction bit says.
  always_ff @(posedge clk)
  begin
    if (rst)
      timer_q <= 1'b0;
    else
      timer_q <= sync2_q.a[`BPAB_TIMER_PIN];
  end

  assign readdata           = rdata_q;
  assign waitrequest        = wait_q;
  assign pins_out           = out_q;
  assign pins_oe            = oe_q;
  assign timer_ext_clock_in = timer_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // A read request first seen, and a write taken, at a given register.
  sequence s_rd_seen(bpab_sel_t s);
    read && wait_q && decode_sel(address) == s;
  endsequence

  sequence s_wr_take(bpab_sel_t s);
    write && !wait_q && byteenable[0] && decode_sel(address) == s;
  endsequence

  a_drive_from_latch: assert property (
    (oe_q.b & (out_q.b ^ $past(latch_b_q))) == 8'h00
  ) else $error("Driven second port pin differs from latch.");

  a_input_floats: assert property (
    (oe_q.a & $past(dir_a_q)) == 6'h00 && (oe_q.b & $past(dir_b_q)) == 8'h00
  ) else $error("Pin driven while its direction bit is set.");

  a_b_latch_write: assert property (
    s_wr_take(BPAB_SEL_B_LATCH) |=> latch_b_q == $past(writedata[7:0])
  ) else $error("Second latch write not stored.");

  a_b_latch_read: assert property (
    s_rd_seen(BPAB_SEL_B_LATCH) ##1 !wait_q |-> readdata == {24'h000000, $past(latch_b_q)}
  ) else $error("Second latch read does not return the latch.");

  a_a_upper_zero: assert property (
    s_rd_seen(BPAB_SEL_A_PINS) or s_rd_seen(BPAB_SEL_A_DIR) or s_rd_seen(BPAB_SEL_A_LATCH)
    |=> readdata[31:6] == 26'h0000000
  ) else $error("First port upper bits not zero.");

  a_analog_reads_zero: assert property (
    s_rd_seen(BPAB_SEL_A_PINS) ##0 ana_w[0] |=> readdata[0] == 1'b0
  ) else $error("Analog pin seen on digital read path.");

  a_analog_still_drives: assert property (
    ana_w[1] && !dir_a_q[1] |=> oe_q.a[1] && out_q.a[1] == $past(latch_a_q[1])
  ) else $error("Analog pin set as output not driven.");

  a_reset_analog: assert property (
    $past(rst) |-> ana_w == `BPAB_ANA_PINS && dir_a_q == `BPAB_DIR_A_RST
  ) else $error("Reset did not leave channel pins analog.");

  a_timer_follows: assert property (
    timer_ext_clock_in == $past(sync2_q.a[4])
  ) else $error("Timer clock input not following the pin.");

  // The synchroniser was cleared by reset, so the pin is only visible three clean edges later.
  a_timer_latency: assert property (
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    |-> timer_ext_clock_in == $past(pins_in.a[4], 3)
  ) else $error("Timer clock input not three cycles behind the pin.");

  a_ref_blocks_pin: assert property (
    ref_en_q |=> !oe_q.a[2]
  ) else $error("Reference output enabled but pin still driven.");

  a_ref_blocks_input: assert property (
    s_rd_seen(BPAB_SEL_A_PINS) ##0 ref_en_q |=> readdata[2] == 1'b0
  ) else $error("Reference pin seen on digital read path.");

  a_a_pins_write: assert property (
    s_wr_take(BPAB_SEL_A_PINS) |=> latch_a_q == $past(writedata[5:0])
  ) else $error("First port pin write did not update latch.");

  a_b_pins_read: assert property (
    s_rd_seen(BPAB_SEL_B_PINS) |=> readdata[7:0] == $past(sync2_q.b)
  ) else $error("Second port pin read wrong.");

  a_b_pins_write: assert property (
    s_wr_take(BPAB_SEL_B_PINS) |=> latch_b_q == $past(writedata[7:0])
  ) else $error("Second port pin write did not update latch.");

  a_b_drive_dir: assert property (
    oe_q.b == ~$past(dir_b_q)
  ) else $error("Second port driver enable does not follow direction.");

  a_a_latch_drive: assert property (
    out_q.a == $past(latch_a_q)
  ) else $error("First port drive value does not follow latch.");

  a_bit_four_digital: assert property (
    s_rd_seen(BPAB_SEL_A_PINS) |=> readdata[4] == $past(sync2_q.a[4])
  ) else $error("First port bit four masked on digital read.");

  a_cfg_write: assert property (
    s_wr_take(BPAB_SEL_CONV_CFG) |=> cfg_q == $past(writedata[3:0])
  ) else $error("Converter pin config write not stored.");

  // A stuck low waitrequest would let one request be taken twice.
  a_wait_one_cycle: assert property (
    !wait_q |=> wait_q
  ) else $error("Waitrequest held low for more than one cycle.");

endmodule : bpab_port_core

// ---- bpab_consts.svh ----
// Register offsets, field positions, reset values and fixed constants of the GPIO ports.
`ifndef BPAB_CONSTS_SVH
`define BPAB_CONSTS_SVH

`define BPAB_OFS_A_PINS   5'h00
`define BPAB_OFS_A_LATCH  5'h04
`define BPAB_OFS_A_DIR    5'h08
`define BPAB_OFS_CONV_CFG 5'h0C
`define BPAB_OFS_B_PINS   5'h10
`define BPAB_OFS_B_LATCH  5'h14
`define BPAB_OFS_B_DIR    5'h18
`define BPAB_OFS_REF_CTRL 5'h1C

`define BPAB_A_WIDTH      6
`define BPAB_B_WIDTH      8
`define BPAB_DIR_A_RST    6'h3F
`define BPAB_DIR_B_RST    8'hFF
`define BPAB_LAT_A_RST    6'h00
`define BPAB_LAT_B_RST    8'h00
`define BPAB_CFG_RST      4'h0
`define BPAB_REF_RST      1'b0
`define BPAB_ANA_LIMIT    4'h7
`define BPAB_ANA_PINS     6'h2F
`define BPAB_TIMER_PIN    4
`define BPAB_REF_PIN      2
`define BPAB_CH_0         4'h0
`define BPAB_CH_1         4'h1
`define BPAB_CH_2         4'h2
`define BPAB_CH_3         4'h3
`define BPAB_CH_4         4'h4

`endif

// ---- bpab_pkg.sv ----
// Types shared by the GPIO port block.
package bpab_pkg;

  // Pin bundle of both ports.
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] b;
  } bpab_pins_t;

  // Register selected by a bus address.
  typedef enum logic [3:0] {
    BPAB_SEL_A_PINS,
    BPAB_SEL_A_LATCH,
    BPAB_SEL_A_DIR,
    BPAB_SEL_CONV_CFG,
    BPAB_SEL_B_PINS,
    BPAB_SEL_B_LATCH,
    BPAB_SEL_B_DIR,
    BPAB_SEL_REF_CTRL,
    BPAB_SEL_NONE
  } bpab_sel_t;

endpackage : bpab_pkg

// ---- bpab_board_model.sv ----
// Board model that drives the port pins and resolves each wire.
module bpab_board_model
  import bpab_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire bpab_pins_t dev_out,
  input  wire bpab_pins_t dev_oe,
  input  wire bpab_pins_t bd_val,
  input  wire bpab_pins_t bd_en,
  output bpab_pins_t      pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt_q;

  // An undriven wire toggles every cycle, so a stale level never passes as a read.
  always_ff @(posedge clk)
  begin
    if (rst)
      flt_q <= 1'b0;
    else
      flt_q <= ~flt_q;
  end

  // The device wins where it drives; the board only drives pins left to it.
  assign pins = (dev_oe & dev_out) | (~dev_oe & bd_en & bd_val)
              | (~dev_oe & ~bd_en & {14{flt_q}});
endmodule : bpab_board_model

// ---- tb_bidir_port_a_b_core.sv ----
// Self-checking testbench of the GPIO port block.
`include "bpab_consts.svh"
module tb_bidir_port_a_b_core
  import bpab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, read, write, waitrequest, tmr;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, q;
  logic [7:0]  d8, l8;
  bpab_pins_t  pins_in, pins_out, pins_oe, bd_val, bd_en;
  int          num_errors, samples_checked, cyc;

  bpab_port_core u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pins_in(pins_in), .pins_out(pins_out),
    .pins_oe(pins_oe), .timer_ext_clock_in(tmr));
  bpab_board_model u_board (.clk(clk), .rst(rst), .dev_out(pins_out), .dev_oe(pins_oe),
    .bd_val(bd_val), .bd_en(bd_en), .pins(pins_in));

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One bus access; waitrequest is sampled at each rising edge, never a fixed count.
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      check("bus answer", 32'h0, 32'h1);
    r = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : xfer

  // Pins 0..3 and 5 carry channels 0..4; channel k is analog while the field is below 7-k.
  function automatic logic [5:0] amask(input logic [3:0] c);
    logic [5:0] m;
    m = 6'h00;
    for (int k = 0; k < 5; k++)
      if (c < 4'(7 - k))
        m[(k < 4) ? k : 5] = 1'b1;
    return m;
  endfunction : amask

  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // Cuts a hang short well above the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  initial
  begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    bd_val = '1;
    bd_en = '1;
    void'($urandom(32'h1E95));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("oe reset", 32'(pins_oe), 32'h0);
    xfer(0, `BPAB_OFS_A_DIR, 0, q); check("a dir", q, 32'h3F);
    xfer(0, `BPAB_OFS_B_DIR, 0, q); check("b dir", q, 32'hFF);
    xfer(0, `BPAB_OFS_CONV_CFG, 0, q); check("cfg", q, 32'h0);
    xfer(0, `BPAB_OFS_A_PINS, 0, q); check("a pins reset", q, 32'h10);
    xfer(1, 5'h02, 32'hFFFFFFFF, q);
    xfer(0, 5'h02, 0, q); check("unmapped", q, 32'h0);
    // Second port: random direction and latch, written through both addresses.
    for (int i = 0; i < 20; i++)
    begin
      d8 = 8'($urandom);
      l8 = (i == 0) ? 8'hFF : 8'($urandom);
      bd_val.b <= 8'($urandom);
      xfer(1, `BPAB_OFS_B_DIR, 32'(d8), q);
      xfer(1, i[0] ? `BPAB_OFS_B_PINS : `BPAB_OFS_B_LATCH, 32'(l8), q);
      repeat (5) @(posedge clk);
      check("b oe", 32'(pins_oe.b), {24'h000000, ~d8});
      check("b out", 32'(pins_out.b & ~d8), 32'(l8 & ~d8));
      xfer(0, `BPAB_OFS_B_LATCH, 0, q); check("b latch", q, 32'(l8));
      xfer(0, `BPAB_OFS_B_PINS, 0, q);
      check("b pins", q, 32'((l8 & ~d8) | (bd_val.b & d8)));
    end
    // First port: every configuration value, all pins inputs.
    for (int c = 0; c < 16; c++)
    begin
      bd_val.a <= 6'($urandom);
      xfer(1, `BPAB_OFS_CONV_CFG, 32'(c), q);
      repeat (5) @(posedge clk);
      xfer(0, `BPAB_OFS_A_PINS, 0, q);
      check("a pins", q, 32'(bd_val.a & ~amask(4'(c))));
    end
    // Outputs still drive while every analog input is enabled.
    xfer(1, `BPAB_OFS_CONV_CFG, 0, q);
    xfer(1, `BPAB_OFS_A_DIR, 0, q);
    xfer(1, `BPAB_OFS_A_PINS, 32'hFFFFFFC5, q);
    repeat (5) @(posedge clk);
    check("a out", 32'(pins_out.a), 32'h05);
    check("a oe", 32'(pins_oe.a), 32'h3F);
    check("timer lo", 32'(tmr), 32'h0);
    xfer(0, `BPAB_OFS_A_LATCH, 0, q); check("a latch", q, 32'h05);
    xfer(1, `BPAB_OFS_A_LATCH, 32'h10, q);
    repeat (5) @(posedge clk);
    check("timer out", 32'(tmr), 32'h1);
    // Reference output takes bit two away from both driver and input.
    xfer(1, `BPAB_OFS_REF_CTRL, 1, q);
    repeat (3) @(posedge clk);
    check("ref oe", 32'(pins_oe.a), 32'h3B);
    bd_val.a <= 6'h3F;
    xfer(1, `BPAB_OFS_A_DIR, 32'h3F, q);
    xfer(1, `BPAB_OFS_CONV_CFG, 32'hF, q);
    repeat (5) @(posedge clk);
    xfer(0, `BPAB_OFS_A_PINS, 0, q); check("ref pins", q, 32'h3B);
    bd_val.a <= 6'h00;
    repeat (5) @(posedge clk);
    check("timer in", 32'(tmr), 32'h0);
    final_report();
  end
endmodule : tb_bidir_port_a_b_core
